// ---- verilog/lpmc_map.svh ----
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH

// Protect bit positions in the write protect register
`define LPMC_PROT_CLK_BIT   0
`define LPMC_PROT_PWR_BIT   1
`define LPMC_PROT_VDET_BIT  3
`define LPMC_PROT_RST       4'h0

// Standby control field encodings
`define LPMC_SBY_SLEEP      2'h0
`define LPMC_SBY_DEEP       2'h1
`define LPMC_SBY_STBY       2'h2
`define LPMC_SBY_RST        2'h0

// Oscillator control field positions and reset value
`define LPMC_OSC_MAIN_BIT   0
`define LPMC_OSC_PLL_BIT    1
`define LPMC_OSC_FAST_BIT   2
`define LPMC_OSC_SLOW_BIT   3
`define LPMC_OSC_RST        4'h8

// Voltage detector control field positions and reset value
`define LPMC_VDET_EN_BIT    0
`define LPMC_VDET_LP_BIT    1
`define LPMC_VDET_RST       2'h0

// Main RAM region retained across low power modes
`define LPMC_RAM_LO         32'h0000_0000
`define LPMC_RAM_HI         32'h0000_2fff

// Operating power control reset value (high-speed)
`define LPMC_OPC_RST        1'h0

`endif

// ---- verilog/lpmc_pkg.sv ----
package lpmc_pkg;

	// Power state of the device, one-hot
	typedef enum logic [3:0] {
		LPMC_RUN   = 4'h1,
		LPMC_SLEEP = 4'h2,
		LPMC_DEEP  = 4'h4,
		LPMC_STBY  = 4'h8
	} lpmc_state_t;

	// Operating power control mode
	typedef enum logic {
		LPMC_HIGH_SPEED   = 1'h0,
		LPMC_MIDDLE_SPEED = 1'h1
	} lpmc_opmode_t;

endpackage

// ---- verilog/lpmc_clkdiv.sv ----
`timescale 1ns/1ps
`default_nettype none

// Programmable divider: one enable pulse every ratio+1 cycles
module lpmc_clkdiv #(
	parameter int DW = 6
) (
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire logic [DW-1:0] ratio,
	output logic               tick
);

	logic [DW-1:0] cnt_q;
	logic          wrap;

	// Wrap when the count reaches the programmed ratio
	assign wrap = (cnt_q >= ratio);

	// Counter and registered enable pulse
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + 1'b1;
			tick  <= wrap;
		end
	end

endmodule

`default_nettype wire

// ---- verilog/lpmc_top.sv ----
// Behaviour
// [R01] Core, peripheral, converter and flash clocks each have their own division ratio.
// [R02] Each peripheral has a stop bit affecting only that peripheral's clock enable.
// [R03] Low power entry needs standby control setting plus a wait instruction.
// [R04] Each mode halts processor, peripherals or oscillators per the selected mode.
// [R05] Besides reset, only an enabled interrupt ends a low power mode.
// [R06] On wake the device services the waking interrupt.
// [R07] Main RAM accessible in sleep, held but not accessible in deeper modes.
// [R08] Retained units freeze operation but keep register contents until wake.
// [R09] Optional units run or stop during a mode per their control setting.
// [R10] Independent watchdog may run in all three modes per its setting.
// [R11] Voltage detector may run in all three modes per its setting.
// [R12] High-speed and middle-speed power modes apply in run, sleep and deep sleep.
// [R13] Clock protect bit gates divider and oscillator control writes.
// [R14] Power protect bit gates standby, module stop, power mode and reset writes.
// [R15] Voltage monitor protect bit gates voltage detector control writes.
// [R16] Software standby stops main, PLL, fast and slow oscillators; holds pins.
// [R17] Deep sleep stops transfer controller and flash; sleep keeps them running.
`include "lpmc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmc_top #(
	parameter int DW   = 6,
	parameter int NMOD = 16
) (
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	input  wire logic            protect_wr,
	input  wire logic [3:0]      protect_wdata,
	input  wire logic            div_wr,
	input  wire logic [4*DW-1:0] div_wdata,
	input  wire logic            osc_wr,
	input  wire logic [3:0]      osc_wdata,
	input  wire logic            mstop_wr,
	input  wire logic [NMOD-1:0] mstop_wdata,
	input  wire logic            sby_wr,
	input  wire logic [1:0]      sby_wdata,
	input  wire logic            opc_wr,
	input  wire logic            opc_wdata,
	input  wire logic            swrst_wr,
	input  wire logic            voltage_detector_wr,
	input  wire logic [1:0]      voltage_detector_wdata,
	input  wire logic            watchdog_lp_run,
	input  wire logic            wait_exec,
	input  wire logic            irq_pending,
	input  wire logic [31:0]     ram_addr,
	input  wire logic            ram_req,
	output logic                 core_clock_en,
	output logic                 peripheral_bus_clock_en,
	output logic                 converter_clock_en,
	output logic                 flash_interface_clock_en,
	output logic [NMOD-1:0]      module_clk_en,
	output logic                 cpu_halt,
	output logic                 transfer_controller_halt,
	output logic                 flash_halt,
	output logic                 main_osc_en,
	output logic                 pll_en,
	output logic                 fast_internal_oscillator_en,
	output logic                 slow_internal_oscillator_en,
	output logic                 wdt_osc_en,
	output logic                 io_hold,
	output logic                 ram_grant,
	output logic                 independent_watchdog_run,
	output logic                 voltage_detector_run,
	output logic                 power_mode,
	output logic                 wake_service,
	output logic                 sw_reset,
	output logic [3:0]           write_protect_register,
	output logic [3:0]           power_state
);

	lpmc_pkg::lpmc_state_t state_q, state_d;
	logic [4*DW-1:0] div_q;
	logic [3:0]      osc_q;
	logic [NMOD-1:0] mstop_q;
	logic [1:0]      sby_q;
	logic            opc_q;
	logic [1:0]      vdet_q;
	logic [3:0]      tick;
	logic [NMOD-1:0] mod_en_d;

	// Write enables after protect gating
	wire clk_ok = write_protect_register[`LPMC_PROT_CLK_BIT]; // [R13]
	wire pwr_ok = write_protect_register[`LPMC_PROT_PWR_BIT]; // [R14]
	wire vdet_ok = write_protect_register[`LPMC_PROT_VDET_BIT]; // [R15]
	wire div_we = div_wr && clk_ok;
	wire osc_we = osc_wr && clk_ok;
	wire mst_we = mstop_wr && pwr_ok;
	wire sby_ok = (sby_wdata != 2'h3);
	wire sby_we = sby_wr && pwr_ok && sby_ok;
	wire opc_we = opc_wr && pwr_ok;
	wire rst_we = swrst_wr && pwr_ok;
	wire vdet_we = voltage_detector_wr && vdet_ok;

	// Mode decode from the registered state
	wire in_run   = (state_q == lpmc_pkg::LPMC_RUN);
	wire in_sleep = (state_q == lpmc_pkg::LPMC_SLEEP);
	wire in_deep  = (state_q == lpmc_pkg::LPMC_DEEP);
	wire in_stby  = (state_q == lpmc_pkg::LPMC_STBY);
	wire in_lp    = !in_run;
	wire ram_hit  = (ram_addr <= `LPMC_RAM_HI); // Region starts at address zero

	// Four independent dividers, one per clock domain
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_div
			lpmc_clkdiv #(.DW(DW)) u_div (
				.ref_clk (ref_clk),
				.resetn  (resetn),
				.ratio   (div_q[g*DW +: DW]), // [R01]
				.tick    (tick[g])
			);
		end
	endgenerate

	// Power state machine: entry on wait, exit on interrupt
	always_comb begin
		state_d = state_q;
		case (state_q)
			lpmc_pkg::LPMC_RUN: begin
				if (wait_exec) begin // [R03]
					case (sby_q)
						`LPMC_SBY_DEEP: state_d = lpmc_pkg::LPMC_DEEP;
						`LPMC_SBY_STBY: state_d = lpmc_pkg::LPMC_STBY;
						default:        state_d = lpmc_pkg::LPMC_SLEEP;
					endcase
				end
			end
			default: begin
				if (irq_pending) begin // [R05]
					state_d = lpmc_pkg::LPMC_RUN;
				end
			end
		endcase
	end

	// Control registers except the protect register, written only when unprotected
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			write_protect_register <= `LPMC_PROT_RST;
			div_q   <= '0;
			osc_q   <= `LPMC_OSC_RST;
			mstop_q <= '1;
			sby_q   <= `LPMC_SBY_RST;
			opc_q   <= `LPMC_OPC_RST;
			vdet_q  <= `LPMC_VDET_RST;
			state_q <= lpmc_pkg::LPMC_RUN;
		end else begin
			if (protect_wr) write_protect_register <= protect_wdata & 4'hb;
			if (div_we) div_q <= div_wdata; // [R13]
			if (osc_we) osc_q <= osc_wdata; // [R13]
			if (mst_we) mstop_q <= mstop_wdata; // [R14]
			if (sby_we) sby_q <= sby_wdata; // [R14]
			if (opc_we) opc_q <= opc_wdata; // [R14] [R12]
			if (vdet_we) vdet_q <= voltage_detector_wdata; // [R15]
			state_q <= state_d;
		end
	end

	// Clock enables, gated by which domains the mode halts
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			core_clock_en            <= 1'b0;
			peripheral_bus_clock_en  <= 1'b0;
			converter_clock_en       <= 1'b0;
			flash_interface_clock_en <= 1'b0;
		end else begin
			core_clock_en            <= tick[0] && in_run; // [R04]
			peripheral_bus_clock_en  <= tick[1] && !in_stby; // [R08]
			converter_clock_en       <= tick[2] && !in_stby;
			flash_interface_clock_en <= tick[3] && !in_deep && !in_stby; // [R17]
		end
	end

	// Per-module clock enables: own stop bit, stopped in standby
	generate
		for (g = 0; g < NMOD; g++) begin : g_mod
			assign mod_en_d[g] = tick[1] && !mstop_q[g] && !in_stby; // [R02] [R09]
		end
	endgenerate

	// One register for all module enables keeps a single writer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			module_clk_en <= '0;
		end else begin
			module_clk_en <= mod_en_d;
		end
	end

	// Halts, oscillators, monitors and wake strobe
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			cpu_halt                    <= 1'b0;
			transfer_controller_halt    <= 1'b0;
			flash_halt                  <= 1'b0;
			main_osc_en                 <= 1'b0;
			pll_en                      <= 1'b0;
			fast_internal_oscillator_en <= 1'b0;
			slow_internal_oscillator_en <= 1'b1;
			wdt_osc_en                  <= 1'b1;
			io_hold                     <= 1'b0;
			ram_grant                   <= 1'b0;
			independent_watchdog_run    <= 1'b1;
			voltage_detector_run        <= 1'b0;
			power_mode                  <= `LPMC_OPC_RST;
			wake_service                <= 1'b0;
			sw_reset                    <= 1'b0;
			power_state                 <= 4'h1;
		end else begin
			cpu_halt                    <= in_lp; // [R04] [R08]
			transfer_controller_halt    <= in_deep || in_stby; // [R17]
			flash_halt                  <= in_deep || in_stby; // [R17]
			main_osc_en                 <= osc_q[`LPMC_OSC_MAIN_BIT] && !in_stby; // [R16]
			pll_en                      <= osc_q[`LPMC_OSC_PLL_BIT] && !in_stby; // [R16]
			fast_internal_oscillator_en <= osc_q[`LPMC_OSC_FAST_BIT] && !in_stby; // [R16]
			slow_internal_oscillator_en <= osc_q[`LPMC_OSC_SLOW_BIT] && !in_stby; // [R16]
			wdt_osc_en                  <= in_run || watchdog_lp_run; // [R10]
			io_hold                     <= in_stby; // [R16]
			ram_grant                   <= ram_req && ram_hit && (in_run || in_sleep); // [R07]
			independent_watchdog_run    <= in_run || watchdog_lp_run; // [R10]
			voltage_detector_run        <= vdet_q[`LPMC_VDET_EN_BIT]
				&& (in_run || vdet_q[`LPMC_VDET_LP_BIT]); // [R11]
			power_mode                  <= opc_q; // [R12]
			wake_service                <= in_lp && irq_pending; // [R06]
			sw_reset                    <= rst_we; // [R14]
			power_state                 <= state_q;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_enter_sleep;
		in_run && wait_exec && (sby_q == `LPMC_SBY_SLEEP);
	endsequence

	sequence s_wake;
		in_lp && irq_pending;
	endsequence

	a_wait_entry: assert property (s_enter_sleep |=> in_sleep) // [R03]
		else $error("Sleep not entered after wait");
	a_no_wait_stay: assert property (in_run && !wait_exec |=> in_run) // [R03]
		else $error("Left run without wait");
	a_lp_hold: assert property (in_lp && !irq_pending |=> $stable(state_q)) // [R05]
		else $error("Low power mode left without interrupt");
	a_wake_service: assert property (s_wake |=> in_run ##0 wake_service) // [R06]
		else $error("Wake did not service interrupt");
	a_stby_osc_off: assert property (in_stby |=> !main_osc_en && !pll_en
		&& !fast_internal_oscillator_en && !slow_internal_oscillator_en && io_hold) // [R16]
		else $error("Oscillator running in standby");
	a_deep_xfer_halt: assert property (in_deep |=> transfer_controller_halt && flash_halt) // [R17]
		else $error("Transfer controller running in deep sleep");
	a_sleep_ram_ok: assert property (in_sleep && ram_req && ram_hit |=> ram_grant) // [R07]
		else $error("RAM not granted in sleep");
	a_mstop_guard: assert property (mstop_wr && !pwr_ok |=> $stable(mstop_q)) // [R14]
		else $error("Module stop written while protected");
	a_div_guard: assert property (div_wr && !clk_ok |=> $stable(div_q)) // [R13]
		else $error("Divider written while protected");
	a_vdet_guard: assert property (voltage_detector_wr && !vdet_ok |=> $stable(vdet_q)) // [R15]
		else $error("Voltage control written while protected");
	a_mod_stopped: assert property (mstop_q[0] |=> !module_clk_en[0]) // [R02]
		else $error("Stopped module still clocked");

endmodule

`default_nettype wire

// ---- testbench/low_power_mode_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_control_tb_top;
	localparam int DW   = 6;
	localparam int NMOD = 16;
	logic            ref_clk, resetn, watchdog_lp_run, wait_exec, irq_pending, ram_req;
	logic            protect_wr, div_wr, osc_wr, mstop_wr, sby_wr, opc_wr, swrst_wr;
	logic            voltage_detector_wr;
	logic [3:0]      protect_wdata, osc_wdata;
	logic [4*DW-1:0] div_wdata;
	logic [NMOD-1:0] mstop_wdata, module_clk_en;
	logic [1:0]      sby_wdata, voltage_detector_wdata;
	logic            opc_wdata;
	logic [31:0]     ram_addr;
	logic            core_clock_en, peripheral_bus_clock_en, converter_clock_en;
	logic            flash_interface_clock_en, cpu_halt, transfer_controller_halt, flash_halt;
	logic            main_osc_en, pll_en, fast_internal_oscillator_en, slow_internal_oscillator_en;
	logic            wdt_osc_en, io_hold, ram_grant, independent_watchdog_run;
	logic            voltage_detector_run, power_mode, wake_service, sw_reset;
	logic [3:0]      write_protect_register, power_state;
	int              num_errors, checks_done, cnt[6];

	lpmc_top #(.DW(DW), .NMOD(NMOD)) lpmc_top_i (
		.ref_clk(ref_clk), .resetn(resetn), .protect_wr(protect_wr),
		.protect_wdata(protect_wdata), .div_wr(div_wr), .div_wdata(div_wdata),
		.osc_wr(osc_wr), .osc_wdata(osc_wdata), .mstop_wr(mstop_wr),
		.mstop_wdata(mstop_wdata), .sby_wr(sby_wr), .sby_wdata(sby_wdata),
		.opc_wr(opc_wr), .opc_wdata(opc_wdata), .swrst_wr(swrst_wr),
		.voltage_detector_wr(voltage_detector_wr),
		.voltage_detector_wdata(voltage_detector_wdata),
		.watchdog_lp_run(watchdog_lp_run), .wait_exec(wait_exec),
		.irq_pending(irq_pending), .ram_addr(ram_addr), .ram_req(ram_req),
		.core_clock_en(core_clock_en), .peripheral_bus_clock_en(peripheral_bus_clock_en),
		.converter_clock_en(converter_clock_en),
		.flash_interface_clock_en(flash_interface_clock_en), .module_clk_en(module_clk_en),
		.cpu_halt(cpu_halt), .transfer_controller_halt(transfer_controller_halt),
		.flash_halt(flash_halt), .main_osc_en(main_osc_en), .pll_en(pll_en),
		.fast_internal_oscillator_en(fast_internal_oscillator_en),
		.slow_internal_oscillator_en(slow_internal_oscillator_en), .wdt_osc_en(wdt_osc_en),
		.io_hold(io_hold), .ram_grant(ram_grant),
		.independent_watchdog_run(independent_watchdog_run),
		.voltage_detector_run(voltage_detector_run), .power_mode(power_mode),
		.wake_service(wake_service), .sw_reset(sw_reset),
		.write_protect_register(write_protect_register), .power_state(power_state));

	// Free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// One-cycle write strobe; sel 0 prot,1 div,2 osc,3 mstop,4 sby,5 opc,6 swrst,7 lvd
	task automatic wr(input int sel, input logic [23:0] d);
		logic [7:0] strb;
		strb = 8'h01 << sel;
		{protect_wdata, osc_wdata, div_wdata} = {d[3:0], d[3:0], d};
		{mstop_wdata, sby_wdata, opc_wdata} = {d[15:0], d[1:0], d[0]};
		voltage_detector_wdata = d[1:0];
		{voltage_detector_wr, swrst_wr, opc_wr, sby_wr} = strb[7:4];
		{mstop_wr, osc_wr, div_wr, protect_wr} = strb[3:0];
		cyc(1);
		{voltage_detector_wr, swrst_wr, opc_wr, sby_wr} = 4'h0;
		{mstop_wr, osc_wr, div_wr, protect_wr} = 4'h0;
		cyc(3);
	endtask

	// Wait instruction, then settle into the selected mode
	task automatic enter();
		wait_exec = 1'b1;
		cyc(1);
		wait_exec = 1'b0;
		cyc(3);
	endtask

	// Raise an interrupt and wait a bounded time for the wake service pulse
	task automatic wake();
		int i;
		irq_pending = 1'b1;
		for (i = 0; i < 10; i++) begin
			cyc(1);
			if (wake_service === 1'b1) break;
		end
		if (i == 10) begin
			num_errors++;
			summarize();
		end
		irq_pending = 1'b0;
		cyc(3);
		chk({power_state, cpu_halt}, {4'h1, 1'b0});
	endtask

	// Counts enable pulses of the four clocks and the modules over a window
	task automatic count(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			cyc(1);
			cnt[0] += core_clock_en;
			cnt[1] += peripheral_bus_clock_en;
			cnt[2] += converter_clock_en;
			cnt[3] += flash_interface_clock_en;
			cnt[4] += module_clk_en[0];
			cnt[5] += |module_clk_en[NMOD-1:1];
		end
	endtask

	// Main sequence
	initial begin
		{resetn, protect_wr, div_wr, osc_wr, mstop_wr, sby_wr, opc_wr, swrst_wr} = 8'h00;
		{voltage_detector_wr, wait_exec, irq_pending} = 3'h0;
		{ram_req, opc_wdata, watchdog_lp_run} = 3'h0;
		{protect_wdata, osc_wdata, div_wdata, mstop_wdata} = '0;
		{sby_wdata, voltage_detector_wdata, ram_addr} = '0;
		num_errors = 0;
		checks_done = 0;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		cyc(1);
		chk({slow_internal_oscillator_en, wdt_osc_en, main_osc_en, cpu_halt}, 4'hc);
		chk({write_protect_register, power_state}, 8'h01);
		wr(2, 24'h000007);
		chk({main_osc_en, pll_en, fast_internal_oscillator_en}, 3'h0);
		wr(4, 24'h000002);
		enter();
		chk({power_state, cpu_halt, transfer_controller_halt, flash_halt}, 7'h14);
		count(20);
		chk(cnt[0], 32'd0);
		chk(cnt[3], 32'd20);
		enter();
		chk(power_state, 4'h2);
		ram_req = 1'b1;
		ram_addr = 32'h0000_2fff;
		cyc(3);
		chk(ram_grant, 1'b1);
		ram_addr = 32'h0000_3000;
		cyc(3);
		chk(ram_grant, 1'b0);
		cyc(20);
		chk(power_state, 4'h2);
		wake();
		wr(0, 24'h00000b);
		chk(write_protect_register, 4'hb);
		wr(2, 24'h000007);
		chk({main_osc_en, pll_en, fast_internal_oscillator_en}, 3'h7);
		wr(1, {6'h07, 6'h04, 6'h01, 6'h03});
		wr(3, 24'h00fffe);
		cyc(20);
		count(40);
		chk(cnt[0], 32'd10);
		chk(cnt[1], 32'd20);
		chk(cnt[2], 32'd8);
		chk(cnt[3], 32'd5);
		chk(cnt[4], 32'd20);
		chk(cnt[5], 32'd0);
		wr(5, 24'h000001);
		chk(power_mode, 1'b1);
		cnt[0] = 0;
		swrst_wr = 1'b1;
		repeat (4) begin
			cyc(1);
			swrst_wr = 1'b0;
			cnt[0] += sw_reset;
		end
		chk(cnt[0], 32'd1);
		wr(7, 24'h000003);
		wr(4, 24'h000001);
		ram_addr = 32'h0000_0000;
		enter();
		chk({power_state, transfer_controller_halt, flash_halt, ram_grant}, 7'h26);
		chk({power_mode, cpu_halt}, 2'h3);
		count(40);
		chk(cnt[0], 32'd0);
		chk(cnt[1], 32'd20);
		chk(cnt[3], 32'd0);
		chk(cnt[4], 32'd20);
		wake();
		watchdog_lp_run = 1'b1;
		wr(4, 24'h000002);
		wr(4, 24'h000003);
		enter();
		chk(power_state, 4'h8);
		chk({main_osc_en, pll_en}, 2'h0);
		chk({fast_internal_oscillator_en, slow_internal_oscillator_en}, 2'h0);
		chk({wdt_osc_en, independent_watchdog_run}, 2'h3);
		chk({io_hold, voltage_detector_run}, 2'h3);
		count(40);
		chk(cnt[1], 32'd0);
		chk(cnt[2], 32'd0);
		chk(cnt[4], 32'd0);
		wake();
		chk({main_osc_en, pll_en, fast_internal_oscillator_en, io_hold}, 4'he);
		summarize();
	end
endmodule

`default_nettype wire
